/* File: rtl/asr_pkg.sv */
package asr_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_PS = 8000;
    // Pin timings in nanoseconds
    localparam int T_RC_NS     = 70;
    localparam int T_AA_NS     = 70;
    localparam int T_WC_NS     = 70;
    localparam int T_PWE_NS    = 50;
    localparam int T_SD_NS     = 30;
    localparam int T_HZWE_NS   = 25;
    localparam int T_LZWE_NS   = 10;
    localparam int T_RECOV_NS  = 100;
    // Cycle counts; minima round up, read sample waits out the full access
    localparam int RD_CYC    = (T_AA_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS + 1;
    localparam int WE_CYC    = (T_PWE_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int SD_CYC    = (T_SD_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int HZ_CYC    = (T_HZWE_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int RECOV_CYC = (T_RECOV_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int WC_CYC    = (T_WC_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int LZ_CYC    = T_LZWE_NS * 1000 / CLK_PERIOD_PS + 1;
    localparam int CNT_W = 5;

    typedef struct packed {
        logic                select_low_active_n;
        logic                select_high_active;
        logic                write_n;
        logic                out_enable_n;
        logic [ADDR_W-1:0]   address_bus;
    } asr_pins_t;

    typedef struct packed {
        logic                write;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } asr_req_t;
endpackage : asr_pkg

/* File: rtl/asr_timer.sv */
`timescale 1ns/100ps
// Loadable down-counter; done_o is a registered one-cycle pulse at zero.
module asr_timer #(
    parameter int W = 5
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              busy_o,
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_d;
    logic         done_q;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (load_i) begin
            cnt_d = value_i;
        end else if (cnt_q != '0) begin
            cnt_d  = cnt_q - W'(1);
            done_d = (cnt_q == W'(1));
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = done_q;
endmodule : asr_timer

/* File: rtl/asr_host.sv */
`timescale 1ns/100ps
module asr_host (
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        req_valid_i,
    input  wire asr_pkg::asr_req_t           req_i,
    output logic                             req_ready_o,
    output logic                             rd_valid_o,
    output logic [asr_pkg::DATA_W-1:0]       rd_data_o,
    output logic                             select_low_active_n_o,
    output logic                             select_high_active_o,
    output logic                             write_n_o,
    output logic                             out_enable_n_o,
    output logic [asr_pkg::ADDR_W-1:0]       address_bus_o,
    input  wire logic [asr_pkg::DATA_W-1:0]  data_bus_i,
    output logic [asr_pkg::DATA_W-1:0]       data_bus_o,
    output logic                             data_bus_oe_n_o
);
    typedef enum logic [2:0] {
        ST_RECOVER, ST_IDLE, ST_RD, ST_WR_GAP, ST_WR_PULSE, ST_WR_END
    } asr_state_t;

    localparam int CW = asr_pkg::CNT_W;

    asr_state_t                    state_q, state_d;
    asr_pkg::asr_pins_t            pins_q, pins_d;
    logic [asr_pkg::DATA_W-1:0]    wdata_q, wdata_d;
    logic                          oe_n_q, oe_n_d;
    logic                          ready_q, ready_d;
    logic                          rvalid_q, rvalid_d;
    logic [asr_pkg::DATA_W-1:0]    rdata_q, rdata_d;
    logic                          t_load;
    logic [CW-1:0]                 t_val;
    logic                          tmr_load;
    logic [CW-1:0]                 tmr_val;
    logic                          t_done;

    asr_timer #(.W(CW)) u_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .load_i    (tmr_load),
        .value_i   (tmr_val),
        .busy_o    (),
        .done_o    (t_done)
    );

    function automatic asr_pkg::asr_pins_t idle_pins(
        input logic [asr_pkg::ADDR_W-1:0] a
    );
        asr_pkg::asr_pins_t p;
        p.select_low_active_n = 1'b1;
        p.select_high_active  = 1'b0;
        p.write_n             = 1'b1;
        p.out_enable_n        = 1'b1;
        p.address_bus         = a;
        return p;
    endfunction : idle_pins

    always_comb begin
        state_d  = state_q;
        pins_d   = pins_q;
        wdata_d  = wdata_q;
        oe_n_d   = oe_n_q;
        ready_d  = 1'b0;
        rvalid_d = 1'b0;
        rdata_d  = rdata_q;
        t_load   = 1'b0;
        t_val    = '0;
        unique case (state_q)
            ST_RECOVER: begin
                if (t_done) begin
                    state_d = ST_IDLE;
                    ready_d = 1'b1;
                end
            end
            ST_IDLE: begin
                ready_d = 1'b1;
                if (req_valid_i && ready_q) begin
                    ready_d = 1'b0;
                    pins_d.address_bus         = req_i.addr;
                    pins_d.select_low_active_n = 1'b0;
                    pins_d.select_high_active  = 1'b1;
                    t_load = 1'b1;
                    if (req_i.write) begin
                        // Wait for the device output to go high-Z first
                        wdata_d = req_i.wdata;
                        t_val   = CW'(asr_pkg::HZ_CYC);
                        state_d = ST_WR_GAP;
                    end else begin
                        pins_d.out_enable_n = 1'b0;
                        t_val   = CW'(asr_pkg::RD_CYC);
                        state_d = ST_RD;
                    end
                end
            end
            ST_RD: begin
                if (t_done) begin
                    rdata_d  = data_bus_i;
                    rvalid_d = 1'b1;
                    pins_d   = idle_pins(pins_q.address_bus);
                    ready_d  = 1'b1;
                    state_d  = ST_IDLE;
                end
            end
            ST_WR_GAP: begin
                if (t_done) begin
                    oe_n_d         = 1'b0;
                    pins_d.write_n = 1'b0;
                    t_load  = 1'b1;
                    t_val   = CW'(asr_pkg::WE_CYC);
                    state_d = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE: begin
                if (t_done) begin
                    // Strobe rises and both selects deassert together; address and data
                    // stay put one more cycle for hold
                    pins_d = idle_pins(pins_q.address_bus);
                    t_load  = 1'b1;
                    t_val   = CW'(asr_pkg::LZ_CYC);
                    state_d = ST_WR_END;
                end
            end
            ST_WR_END: begin
                oe_n_d = 1'b1;
                if (t_done) begin
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q  <= ST_RECOVER;
            pins_q   <= '{select_low_active_n: 1'b1, select_high_active: 1'b0,
                          write_n: 1'b1, out_enable_n: 1'b1,
                          address_bus: '0};
            wdata_q  <= '0;
            oe_n_q   <= 1'b1;
            ready_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
        end else begin
            state_q  <= state_d;
            pins_q   <= pins_d;
            wdata_q  <= wdata_d;
            oe_n_q   <= oe_n_d;
            ready_q  <= ready_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
        end
    end

    // Recovery timer is kicked once right after reset release
    logic kick_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= 1'b1;
        end
    end

    logic kick_load;
    assign kick_load = !kick_q;

    // Timer load is the FSM load or the one-shot recovery start
    logic [CW-1:0] recov_val;
    assign recov_val = CW'(asr_pkg::RECOV_CYC);

    // The FSM never loads the timer while recovering, so the two loads
    // cannot collide; without the kick the FSM would wait forever
    assign tmr_load = t_load || kick_load;
    assign tmr_val  = kick_load ? recov_val : t_val;

    assign req_ready_o           = ready_q;
    assign rd_valid_o            = rvalid_q;
    assign rd_data_o             = rdata_q;
    assign select_low_active_n_o = pins_q.select_low_active_n;
    assign select_high_active_o  = pins_q.select_high_active;
    assign write_n_o             = pins_q.write_n;
    assign out_enable_n_o        = pins_q.out_enable_n;
    assign address_bus_o         = pins_q.address_bus;
    assign data_bus_o            = wdata_q;
    assign data_bus_oe_n_o       = oe_n_q;
endmodule : asr_host

/* File: verif/asr_host_props.sv */
`timescale 1ns/100ps
module asr_host_props (
    input wire logic                       clk_i,
    input wire logic                       reset_n_i,
    input wire logic                       rd_valid_o,
    input wire logic                       select_low_active_n_o,
    input wire logic                       select_high_active_o,
    input wire logic                       write_n_o,
    input wire logic                       out_enable_n_o,
    input wire logic [asr_pkg::ADDR_W-1:0] address_bus_o,
    input wire logic [asr_pkg::DATA_W-1:0] data_bus_o,
    input wire logic                       data_bus_oe_n_o
);
    logic [3:0] since_q, since_d;
    logic       sel;
    assign sel = !select_low_active_n_o && select_high_active_o;
    // Saturates so the recovery check stays true in long runs
    always_comb since_d = since_q + {3'h0, since_q != 4'hf};
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i) since_q <= 4'h0;
        else since_q <= since_d;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_recover_wait: assert property (
        (!select_low_active_n_o || select_high_active_o) |-> since_q >= 4'hd)
        else $error("device selected too soon after reset");
    a_read_pins: assert property (!out_enable_n_o |-> sel && write_n_o)
        else $error("read pins wrong");
    a_write_pins: assert property (
        !write_n_o |-> sel && !data_bus_oe_n_o)
        else $error("write pins wrong");
    a_no_contention: assert property (
        !data_bus_oe_n_o |-> out_enable_n_o)
        else $error("host drives while output enabled");
    a_strobe_width: assert property ($fell(write_n_o) |-> !write_n_o[*7])
        else $error("strobe too short");
    a_data_setup: assert property ($rose(write_n_o) |->
        $past(data_bus_o, 4) == data_bus_o && !$past(data_bus_oe_n_o, 4))
        else $error("write data setup short");
    a_addr_steady: assert property (
        (!write_n_o || $rose(write_n_o)) |-> $stable(address_bus_o))
        else $error("address moved in write");
    a_sel_setup: assert property ($rose(write_n_o) |-> $past(sel, 8))
        else $error("select setup short");
    a_read_settle: assert property (
        $rose(rd_valid_o) |-> !$past(out_enable_n_o, 9))
        else $error("read sampled too early");
    a_read_latency: assert property (
        $fell(out_enable_n_o) |-> ##[9:12] rd_valid_o)
        else $error("read result late");
    c_write: cover property ($rose(write_n_o));
    c_read: cover property ($rose(rd_valid_o));
    c_busy: cover property (sel ##1 !sel);
endmodule : asr_host_props
bind asr_host asr_host_props i_props (.clk_i, .reset_n_i, .rd_valid_o,
    .select_low_active_n_o, .select_high_active_o, .write_n_o,
    .out_enable_n_o, .address_bus_o, .data_bus_o, .data_bus_oe_n_o);

/* File: verif/asr_sram_model.sv */
`timescale 1ns/100ps
module asr_sram_model (
    input  wire logic        clk_i,
    input  wire logic        sel_lo_n_i,
    input  wire logic        sel_hi_i,
    input  wire logic        wr_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [17:0] addr_i,
    input  wire logic [7:0]  host_d_i,
    input  wire logic        host_oe_n_i,
    output logic      [7:0]  dq_o
);
    logic [7:0]  mem [2**18];
    logic [17:0] a_late, a_out;
    logic        sel, sel_d, oe_d, we_d, wr, rd, ok;
    logic        wr_q = 1'b0;
    logic [7:0]  junk = 8'h5a;
    assign sel = !sel_lo_n_i && sel_hi_i;
    assign wr = sel && !wr_n_i;
    // Inertial delays: a value only passes once its input has held still
    assign #70 a_late = addr_i;
    assign #70 sel_d = sel;
    assign #35 oe_d = oe_n_i;
    assign #10 we_d = wr_n_i;
    assign #10 a_out = addr_i;
    // Deselect at strobe rise leaves rd low, so the bus never glitches
    assign rd = sel && wr_n_i && we_d && !oe_n_i;
    assign ok = sel_d && !oe_d && a_late === a_out;
    // Released bus shows a moving pattern, never the last byte
    always @(posedge clk_i) junk <= junk + 8'h5b;
    always @(wr) begin
        if (wr_q === 1'b1 && wr === 1'b0) mem[addr_i] = host_d_i;
        wr_q = wr;
    end
    assign dq_o = !host_oe_n_i ? host_d_i :
                  (rd && ok) ? mem[a_out] : junk;
endmodule : asr_sram_model

/* File: verif/test_async_sram_256k_by_8.sv */
`timescale 1ns/100ps
module test_async_sram_256k_by_8;
    logic              clk_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic              req_valid_i = 1'b0;
    asr_pkg::asr_req_t req_i = '0;
    logic              req_ready_o, rd_valid_o, sl_n, sh, wr_n, oe_n, d_oe_n;
    logic [7:0]        rd_data_o, dq_o, dq_i, pins;
    logic [17:0]       addr;
    int                fails = 0;
    int                num_checks = 0;
    int                wr_low = 0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (wr_n === 1'b0) wr_low++;
    assign pins = {sl_n, sh, wr_n, oe_n, d_oe_n, req_ready_o, 2'h0};
    asr_host i_dut (.clk_i, .reset_n_i, .req_valid_i, .req_i, .req_ready_o,
        .rd_valid_o, .rd_data_o, .select_low_active_n_o(sl_n),
        .select_high_active_o(sh), .write_n_o(wr_n), .out_enable_n_o(oe_n),
        .address_bus_o(addr), .data_bus_i(dq_i), .data_bus_o(dq_o),
        .data_bus_oe_n_o(d_oe_n));
    asr_sram_model i_mem (.clk_i, .sel_lo_n_i(sl_n), .sel_hi_i(sh),
        .wr_n_i(wr_n), .oe_n_i(oe_n), .addr_i(addr), .host_d_i(dq_o),
        .host_oe_n_i(d_oe_n), .dq_o(dq_i));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
            if (n > 80) begin
                fails++;
                summarize();
            end
        end while (req_ready_o !== 1'b1);
    endtask : wait_ready
    task automatic issue(input logic w, input logic [17:0] a,
                         input logic [7:0] d);
        int n;
        wait_ready(n);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{write: w, addr: a, wdata: d};
        @(posedge clk_i);
        req_valid_i <= 1'b0;
    endtask : issue
    task automatic read_chk(input logic [17:0] a, input logic [7:0] exp);
        int n;
        issue(1'b0, a, 8'h00);
        n = 0;
        while (rd_valid_o !== 1'b1) begin
            @(negedge clk_i);
            n++;
            if (n > 40) begin
                fails++;
                summarize();
            end
        end
        check(rd_data_o, exp);
    endtask : read_chk
    task automatic t_reset;
        int n;
        check(pins, 8'hb8);
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        wait_ready(n);
        check(8'(n > asr_pkg::RECOV_CYC), 8'h01);
        $display("reset test done");
    endtask : t_reset
    task automatic t_rw;
        logic [17:0] a [3] = '{18'h00000, 18'h3ffff, 18'h15a5a};
        logic [7:0]  d [3] = '{8'ha5, 8'h5a, 8'hff};
        for (int i = 0; i < 3; i++) issue(1'b1, a[i], d[i]);
        for (int i = 0; i < 3; i++) read_chk(a[i], d[i]);
        $display("write read test done");
    endtask : t_rw
    task automatic t_overwrite;
        issue(1'b1, 18'h00001, 8'h3c);
        issue(1'b1, 18'h00002, 8'hc3);
        issue(1'b1, 18'h00001, 8'h00);
        read_chk(18'h00001, 8'h00);
        read_chk(18'h00002, 8'hc3);
        $display("overwrite test done");
    endtask : t_overwrite
    task automatic t_pulse;
        int n;
        wr_low = 0;
        issue(1'b1, 18'h20000, 8'h81);
        wait_ready(n);
        check(wr_low[7:0], 8'(asr_pkg::WE_CYC + 1));
        read_chk(18'h20000, 8'h81);
        $display("strobe test done");
    endtask : t_pulse
    task automatic t_mid_reset;
        issue(1'b1, 18'h00003, 8'h99);
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b0;
        @(negedge clk_i);
        check(pins, 8'hb8);
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        read_chk(18'h00002, 8'hc3);
        $display("mid reset test done");
    endtask : t_mid_reset
    initial begin
        repeat (3) @(posedge clk_i);
        t_reset();
        t_rw();
        t_overwrite();
        t_pulse();
        t_mid_reset();
        summarize();
    end
endmodule : test_async_sram_256k_by_8
